/* File: rtl/csbc_top.sv */
// Completion output, boot copy into the boot buffer and data buffer fill.
// Assumes reset_pin_n is asynchronous to clk_i; other inputs are same-clock logic.
// Function
// [RL1] Host clears status bit before each command
// [RL2] Default polarity idle: completion output high
// [RL3] Command finish returns completion output high
// [RL4] Open-drain completion, always driven, never floats; the code only drives low and releases the pin otherwise
// [RL5] Host may poll status bit instead
// [RL6] Asynchronous wiring: clock grounded, ready open
// [RL7] Synchronous wiring: all lines connected directly
// [RL8] Power-up copies 1KB boot code to buffer
// [RL9] Two 2KB data buffers filled by load
// [RL10] Host streams beyond 3KB via both buffers
// [RL11] Boot copy starts 400us after power-on
// [RL12] Status rises after copy done and reset release
// [RL13] Non-default polarity inverts completion levels
module csbc_top #(
	parameter int BOOT_DELAY = csbc_pkg::BOOT_DELAY_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic reset_pin_n_i,
	// Status and command from the register logic
	input wire logic int_clr_i,
	input wire logic pol_i,
	input wire logic [csbc_pkg::CMD_W-1:0] cmd_i,
	input wire logic cmd_done_i,
	input wire logic load_buf_i,
	// Flash core word
	input wire logic [15:0] core_word_i,
	// Host buffer read
	input wire logic boot_sel_i,
	input wire logic rd_buf_i,
	input wire logic [csbc_pkg::DATA_AW:0] rd_addr_i,
	output logic [15:0] rd_data_o,
	// Completion pin and status
	input wire logic int_pin_i,
	output logic int_pin_o,
	output logic int_pin_oe_n_o,
	output logic int_status_o,
	output logic boot_done_o,
	output logic busy_o
);
	import csbc_pkg::*;
	csbc_array_if arr();
	csbc_array_port u_port (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.core_word_i(core_word_i),
		.arr(arr)
	);
	logic [15:0] boot_mem [BOOT_WORDS];
	logic [15:0] data_mem0 [DATA_WORDS];
	logic [15:0] data_mem1 [DATA_WORDS];
	csbc_boot_t boot_ff, nxt_boot;
	logic [31:0] dly_ff;
	logic [DATA_AW:0] cnt_ff;
	logic filling_ff, fill_buf_ff, boot_wr, data_wr;
	logic rp_s1_ff, rp_s2_ff, rp_seen_ff;
	logic int_ff, cmd_active_ff;
	logic boot_irq_ff, boot_rise, fill_last, cmd_fin;
	logic [15:0] rd_data_ff;
	logic unused_pin;
	assign unused_pin = int_pin_i;

	// Reset pin synchroniser and sticky release
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rp_s1_ff <= 1'b0;
			rp_s2_ff <= 1'b0;
			rp_seen_ff <= 1'b0;
		end else begin
			rp_s1_ff <= reset_pin_n_i;
			rp_s2_ff <= rp_s1_ff;
			if (rp_s2_ff)
				rp_seen_ff <= 1'b1;
		end
	end

	// Boot state sequencing
	always_comb begin
		nxt_boot = boot_ff;
		case (boot_ff)
			CSBC_WAIT: if (dly_ff == 32'(BOOT_DELAY - 1)) nxt_boot = CSBC_COPY; // RL11
			CSBC_COPY: if (arr.rvalid && cnt_ff == (DATA_AW+1)'(BOOT_WORDS - 1))
				nxt_boot = CSBC_DONE; // RL8
			CSBC_DONE: nxt_boot = CSBC_DONE;
			default: nxt_boot = CSBC_WAIT;
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			boot_ff <= CSBC_WAIT;
		else
			boot_ff <= nxt_boot;
	end

	// Power-on delay counter
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			dly_ff <= 32'h0;
		else if (boot_ff == CSBC_WAIT)
			dly_ff <= dly_ff + 32'h1; // RL11
	end

	// Array requests, word counter for copy and fill
	assign arr.req = (boot_ff == CSBC_COPY || filling_ff) && !arr.rvalid;
	assign arr.addr = 16'(cnt_ff);
	assign boot_wr = boot_ff == CSBC_COPY && arr.rvalid;
	assign data_wr = filling_ff && arr.rvalid;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_ff <= '0;
			filling_ff <= 1'b0;
			fill_buf_ff <= 1'b0;
		end else begin
			if (boot_wr || data_wr)
				cnt_ff <= cnt_ff + (DATA_AW+1)'(1);
			if (nxt_boot == CSBC_DONE && boot_ff == CSBC_COPY)
				cnt_ff <= '0;
			// A load is refused while another command is outstanding
			if (boot_ff == CSBC_DONE && load_buf_i && !filling_ff && !cmd_active_ff &&
				cmd_i == CMD_LOAD) begin
				filling_ff <= 1'b1; // RL9
				fill_buf_ff <= boot_sel_i;
				cnt_ff <= '0;
			end else if (data_wr && cnt_ff == (DATA_AW+1)'(DATA_WORDS - 1)) begin
				filling_ff <= 1'b0;
				cnt_ff <= '0;
			end
		end
	end

	// Buffer writes
	always_ff @(posedge clk_i) begin
		if (boot_wr)
			boot_mem[cnt_ff[BOOT_AW-1:0]] <= arr.rdata; // RL8
		if (data_wr && !fill_buf_ff)
			data_mem0[cnt_ff[DATA_AW-1:0]] <= arr.rdata; // RL9
		if (data_wr && fill_buf_ff)
			data_mem1[cnt_ff[DATA_AW-1:0]] <= arr.rdata; // RL9
	end

	// Host read port: boot buffer, or the data buffer picked by the top address bit
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			rd_data_ff <= 16'h0000;
		else if (rd_buf_i) begin
			if (!boot_sel_i)
				rd_data_ff <= boot_mem[rd_addr_i[BOOT_AW-1:0]];
			else if (!rd_addr_i[DATA_AW])
				rd_data_ff <= data_mem0[rd_addr_i[DATA_AW-1:0]];
			else
				rd_data_ff <= data_mem1[rd_addr_i[DATA_AW-1:0]];
		end
	end
	assign rd_data_o = rd_data_ff;

	// Completion events; the boot rise fires once per reset, so a later clear stays low
	assign boot_rise = boot_ff == CSBC_DONE && rp_seen_ff && !boot_irq_ff; // RL12
	assign fill_last = data_wr && cnt_ff == (DATA_AW+1)'(DATA_WORDS - 1);
	assign cmd_fin = cmd_done_i || fill_last;

	// Interrupt status bit: set wins over clear
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			int_ff <= RST_INT_FF;
			cmd_active_ff <= 1'b0;
			boot_irq_ff <= 1'b0;
		end else begin
			if (cmd_i != CMD_NONE && !cmd_active_ff && boot_ff == CSBC_DONE)
				cmd_active_ff <= 1'b1;
			if (cmd_fin)
				cmd_active_ff <= 1'b0;
			if (boot_rise)
				boot_irq_ff <= 1'b1;
			if (boot_rise)
				int_ff <= 1'b1; // RL12
			else if (cmd_active_ff && cmd_fin)
				int_ff <= 1'b1; // RL3
			else if (int_clr_i)
				int_ff <= 1'b0; // RL1
		end
	end

	// Open-drain drive: pull low when level is low, release otherwise
	logic pin_level;
	assign pin_level = pol_i ? int_ff : !int_ff; // RL13
	assign int_pin_o = 1'b0; // RL4
	assign int_pin_oe_n_o = pin_level; // RL2
	assign int_status_o = int_ff; // RL5
	assign boot_done_o = boot_ff == CSBC_DONE;
	assign busy_o = cmd_active_ff;

	property p_boot_start;
		@(posedge clk_i) disable iff (sys_rst_i)
			$rose(boot_ff == CSBC_COPY) |-> $past(dly_ff) == 32'(BOOT_DELAY - 1);
	endproperty
	a_boot_start: assert property (p_boot_start) else $error("boot copy mistimed"); // RL11
	property p_idle_high;
		@(posedge clk_i) disable iff (sys_rst_i) (int_ff && pol_i) |-> int_pin_oe_n_o;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("idle pin not released"); // RL2
	property p_pol_inv;
		@(posedge clk_i) disable iff (sys_rst_i) (int_ff && !pol_i) |-> !int_pin_oe_n_o;
	endproperty
	a_pol_inv: assert property (p_pol_inv) else $error("polarity not inverted"); // RL13
	property p_done_rise;
		@(posedge clk_i) disable iff (sys_rst_i) (cmd_active_ff && cmd_done_i) |=> int_ff;
	endproperty
	a_done_rise: assert property (p_done_rise) else $error("status missed completion"); // RL3
	property p_rise_cond;
		@(posedge clk_i) disable iff (sys_rst_i)
			$rose(int_ff) |-> $past(boot_ff == CSBC_DONE) && $past(rp_seen_ff);
	endproperty
	a_rise_cond: assert property (p_rise_cond) else $error("status rose too early"); // RL12
	property p_pin_low;
		@(posedge clk_i) disable iff (sys_rst_i) int_pin_o == 1'b0;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("open-drain drove high"); // RL4
	property p_copy_len;
		@(posedge clk_i) disable iff (sys_rst_i)
			$rose(boot_ff == CSBC_DONE) |-> $past(cnt_ff) == (DATA_AW+1)'(BOOT_WORDS - 1);
	endproperty
	a_copy_len: assert property (p_copy_len) else $error("boot copy length wrong"); // RL8
	property p_fill_end;
		@(posedge clk_i) disable iff (sys_rst_i)
			(data_wr && cnt_ff == (DATA_AW+1)'(DATA_WORDS - 1)) |=> !filling_ff;
	endproperty
	a_fill_end: assert property (p_fill_end) else $error("fill ran past buffer"); // RL9
	property p_clear;
		@(posedge clk_i) disable iff (sys_rst_i)
			(int_clr_i && !boot_rise && !(cmd_active_ff && cmd_fin)) |=> !int_ff;
	endproperty
	a_clear: assert property (p_clear) else $error("clear ignored"); // RL1
	c_boot: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(boot_ff == CSBC_DONE));
	c_cmd: cover property (@(posedge clk_i) disable iff (sys_rst_i) cmd_active_ff && cmd_done_i);
	c_fill: cover property (@(posedge clk_i) disable iff (sys_rst_i) $fell(filling_ff));
endmodule

/* File: rtl/csbc_pkg.sv */
// Package for the completion signalling and boot copy block.
// Assumes a single 50 MHz clock domain.
package csbc_pkg;
	localparam int CLK_MHZ = 50;
	// Delay from power-on detect to start of boot copy
	localparam int BOOT_DELAY_US = 400;
	localparam int BOOT_DELAY_CYC = BOOT_DELAY_US * CLK_MHZ;
	localparam int BOOT_BYTES = 1024;
	localparam int BOOT_WORDS = BOOT_BYTES / 2;
	localparam int DATA_BYTES = 2048;
	localparam int DATA_WORDS = DATA_BYTES / 2;
	localparam int BOOT_AW = 9;
	localparam int DATA_AW = 10;
	localparam int CMD_W = 2;
	localparam logic [CMD_W-1:0] CMD_NONE = 2'h0;
	localparam logic [CMD_W-1:0] CMD_LOAD = 2'h1;
	localparam logic [CMD_W-1:0] CMD_PROG = 2'h2;
	localparam logic [CMD_W-1:0] CMD_ERASE = 2'h3;
	localparam logic RST_INT_FF = 1'b0;
	localparam logic RST_POL_DEFAULT = 1'b1;
	typedef enum logic [1:0] {
		CSBC_WAIT = 2'b00,
		CSBC_COPY = 2'b01,
		CSBC_DONE = 2'b11
	} csbc_boot_t;
endpackage

/* File: rtl/csbc_array_if.sv */
// Interface between the top and the flash array word source.
// Assumes one clock shared by both ends.
interface csbc_array_if;
	logic req;
	logic [15:0] addr;
	logic [15:0] rdata;
	logic rvalid;
	modport ctrl(output req, output addr, input rdata, input rvalid);
	modport src(input req, input addr, output rdata, output rvalid);
endinterface

/* File: rtl/csbc_array_port.sv */
// Registered flash array word read port: one cycle latency.
// Assumes array contents arrive on a plain word input from outside logic.
module csbc_array_port (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Array word from the flash core
	input wire logic [15:0] core_word_i,
	csbc_array_if.src arr
);
	import csbc_pkg::*;
	// Return the core word one cycle after the request
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			arr.rvalid <= 1'b0;
			arr.rdata <= 16'h0000;
		end else begin
			arr.rvalid <= arr.req;
			arr.rdata <= core_word_i;
		end
	end
endmodule

/* File: dv/csbc_host_model.sv */
// Host-side partner: pull-up on the completion line, edge detect, flash words.
// Assumes one clock shared with the device.
module csbc_host_model (
	// Clock
	input wire logic clk_i,
	// Completion pin and fill select from the device side
	input wire logic pin_drv_i,
	input wire logic oe_n_i,
	input wire logic sel_i,
	// Resolved line and flash word
	output logic pin_o,
	output logic rise_o,
	output logic [15:0] core_word_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pin_ff = 1'b1;
	// Pull-up wins unless the device pulls low, line goes straight to a host input
	assign pin_o = oe_n_i ? 1'b1 : pin_drv_i;
	// Host input edge detector
	always_ff @(posedge clk_i) begin
		pin_ff <= pin_o;
	end
	assign rise_o = pin_o & ~pin_ff;
	// Fills with sel_i high (data buffer 1) see the inverted pattern
	assign core_word_o = sel_i ? 16'ha5c3 : 16'h5a3c;
endmodule

/* File: dv/csbc_tb_top.sv */
// Testbench for completion signalling and boot copy.
// Assumes the host model resolves the pin; boot delay shortened to 50 cycles.
module csbc_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import csbc_pkg::*;
	localparam int BD = 50;
	localparam logic [15:0] WORD = 16'h5a3c;
	logic clk_i = 0, sys_rst_i = 1, reset_pin_n_i = 0, int_clr_i = 0, pol_i = 1;
	logic cmd_done_i = 0, load_buf_i = 0, boot_sel_i = 0, rd_buf_i = 0;
	logic [CMD_W-1:0] cmd_i = CMD_NONE;
	logic [DATA_AW:0] rd_addr_i = '0;
	logic [15:0] core_word, rd_data;
	logic pin_drv, oe_n, pin, rise, status, boot_done, busy;
	int miscompares = 0, cmp_count = 0, cycles = 0;
	csbc_top #(.BOOT_DELAY(BD)) u_csbc_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.reset_pin_n_i(reset_pin_n_i), .int_clr_i(int_clr_i), .pol_i(pol_i), .cmd_i(cmd_i),
		.cmd_done_i(cmd_done_i), .load_buf_i(load_buf_i), .core_word_i(core_word),
		.boot_sel_i(boot_sel_i), .rd_buf_i(rd_buf_i), .rd_addr_i(rd_addr_i),
		.rd_data_o(rd_data), .int_pin_i(pin), .int_pin_o(pin_drv), .int_pin_oe_n_o(oe_n),
		.int_status_o(status), .boot_done_o(boot_done), .busy_o(busy));
	csbc_host_model u_csbc_host_model (.clk_i(clk_i), .pin_drv_i(pin_drv), .oe_n_i(oe_n),
		.sel_i(boot_sel_i), .pin_o(pin), .rise_o(rise), .core_word_o(core_word));
	// Clock and hang guard
	initial forever #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end
	task automatic final_report();
		$display("cmp_count=%0d miscompares=%0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Step n edges, then let updates settle
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// Poll the status bit under a bound
	task automatic wait_hi(input int n);
		for (int i = 0; i < n && status !== 1'b1; i++) cyc(1);
	endtask
	task automatic wait_boot();
		for (int i = 0; i < 2000 && boot_done !== 1'b1; i++) cyc(1);
	endtask
	task automatic rd(input logic sel, input logic [DATA_AW:0] a, input logic [15:0] exp);
		@(posedge clk_i) begin
			boot_sel_i <= sel;
			rd_buf_i <= 1'b1;
			rd_addr_i <= a;
		end
		@(posedge clk_i) rd_buf_i <= 1'b0;
		#1 chk(rd_data, exp);
	endtask
	// Power-up: delayed copy, status held until the reset pin rises
	task automatic t_boot();
		cyc(BD + 1000);
		chk(boot_done, 0);
		wait_boot();
		chk(boot_done, 1);
		cyc(8);
		chk(status, 0);
		@(posedge clk_i) reset_pin_n_i <= 1'b1;
		cyc(1);
		wait_hi(6);
		chk(status, 1);
		chk(pin, 1);
		rd(0, 0, WORD);
		rd(0, 511, WORD);
	endtask
	// Clear, issue, finish; pin follows the polarity
	task automatic t_cmd(input logic [CMD_W-1:0] code, input logic sel);
		@(posedge clk_i) int_clr_i <= 1'b1;
		@(posedge clk_i) begin
			int_clr_i <= 1'b0;
			cmd_i <= code;
			load_buf_i <= (code == CMD_LOAD);
			boot_sel_i <= sel;
		end
		#1 chk(status, 0);
		chk(pin, !pol_i);
		@(posedge clk_i) begin
			cmd_i <= CMD_NONE;
			load_buf_i <= 1'b0;
		end
		#1 chk(busy, 1);
		if (code != CMD_LOAD) begin
			@(posedge clk_i) cmd_i <= CMD_ERASE;
			@(posedge clk_i) cmd_i <= CMD_NONE;
			@(posedge clk_i) cmd_done_i <= 1'b1;
			@(posedge clk_i) cmd_done_i <= 1'b0;
			#1 wait_hi(4);
		end
		else wait_hi(3000);
		chk(status, 1);
		chk(rise, pol_i);
		cyc(2);
		chk(busy, 0);
		chk(pin, pol_i);
	endtask
	// Dual buffering: read buffer 0 while buffer 1 fills, then read buffer 1
	task automatic t_dual();
		@(posedge clk_i) int_clr_i <= 1'b1;
		@(posedge clk_i) begin
			int_clr_i <= 1'b0;
			cmd_i <= CMD_LOAD;
			load_buf_i <= 1'b1;
			boot_sel_i <= 1'b1;
		end
		@(posedge clk_i) begin
			cmd_i <= CMD_NONE;
			load_buf_i <= 1'b0;
		end
		#1 chk(busy, 1);
		rd(1, 11'h3ff, WORD);
		chk(status, 0);
		wait_hi(3000);
		chk(status, 1);
		rd(1, 11'h7ff, 16'ha5c3);
	endtask
	// Warm restart with the reset pin already high; early command refused
	task automatic t_warm();
		@(posedge clk_i) sys_rst_i <= 1'b1;
		cyc(3);
		chk(status, 0);
		chk(pin, 0);
		@(posedge clk_i) sys_rst_i <= 1'b0;
		@(posedge clk_i) cmd_i <= CMD_PROG;
		@(posedge clk_i) cmd_i <= CMD_NONE;
		#1 chk(busy, 0);
		wait_boot();
		wait_hi(4);
		chk(status, 1);
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		#1 chk(status, 0);
		t_boot();
		t_cmd(CMD_PROG, 1'b1);
		t_cmd(CMD_LOAD, 1'b1);
		rd(1, 11'h400, 16'ha5c3);
		t_cmd(CMD_LOAD, 1'b0);
		t_dual();
		@(posedge clk_i) pol_i <= 1'b0;
		t_cmd(CMD_ERASE, 1'b1);
		@(posedge clk_i) pol_i <= 1'b1;
		t_warm();
		final_report();
	end
endmodule
